// File: wdc_ctrl_regs.sv
// Contract
// - writing latch clear releases driver shutdown
// - clear held high blocks new shutdowns
// - run enable low forces driver off, floats
// - run enable high still obeys shutdown sources
// - source select 0 waveform, 1 pattern
// - pattern mode needs select and enable
// - keep bit decides converter off on shutdown
// - power-down bit sleeps converter, resets to 1
// - code format: binary or two's complement
// - edge select picks rising or falling step
// - index wraps after last-index field value
// - reinit restores registers, starts reboot sequence
//
// Purpose: control register group of the waveform driver digital engine
// Assumes: register reads return data the cycle after the read strobe
// Notes: shutdown and fault requests are synchronous level inputs
//
// The implementer's own choices: the address map and the plain strobed port.

`timescale 1ns/10ps
`default_nettype none
module wdc_ctrl_regs (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [wdc_pkg::ADDR_W-1:0] addr_in,
    input wire logic [wdc_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [wdc_pkg::DATA_W-1:0] rdata_out,
    input wire logic shutdown_pin_in,
    input wire logic fault_in,
    input wire logic step_strobe_in,
    output logic driver_enable_out,
    output logic driver_float_out,
    output logic converter_on_out,
    output logic pattern_mode_out,
    output logic twos_complement_out,
    output logic [3:0] pattern_index_out,
    output logic pattern_update_out,
    output logic rebooting_out
);
    import wdc_pkg::*;

    typedef enum logic [1:0] {ST_RUN, ST_REBOOT} wdc_eng_t;

    typedef struct packed {
        wdc_regs_t regs;
        logic sd_latch;
        logic [3:0] idx;
        logic upd;
        wdc_eng_t eng;
        logic [3:0] boot_cnt;
        logic [DATA_W-1:0] rdata;
        logic drv_en;
        logic drv_float;
        logic cnv_on;
        logic pat_mode;
        logic twos;
        logic booting;
    } wdc_state_t;

    wdc_state_t st_q, st_d;
    wdc_step_if step_if();

    wdc_step_det u_det (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .strobe_in(step_strobe_in),
        .step_if(step_if)
    );

    // ----------------------------------------
    // derived controls
    // ----------------------------------------
    logic clear_held;
    logic run_en;
    logic pat_active;
    logic drv_on;
    logic reinit_wr;
    assign clear_held = st_q.regs.drv[BIT_LATCH_CLEAR];
    // reinit is only taken while running, matching the write decode below
    assign reinit_wr = wr_in && addr_in == OFS_REINIT && wdata_in[BIT_REINIT]
        && st_q.eng == ST_RUN;
    assign run_en = st_q.regs.drv[BIT_RUN_ENABLE];
    assign pat_active = st_q.regs.drv[BIT_SRC_SELECT] & st_q.regs.pat[BIT_PAT_ENABLE];
    assign step_if.edge_sel = st_q.regs.pat[BIT_EDGE_SEL];
    // shutdown latch gates the driver unless run enable forces it off outright
    assign drv_on = run_en & ~st_q.sd_latch;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.upd = 1'b0;
        st_d.rdata = '0;
        // latch clear both releases and masks new requests
        if (clear_held) begin
            st_d.sd_latch = 1'b0;
        end else if (shutdown_pin_in | fault_in) begin
            st_d.sd_latch = 1'b1;
        end
        // pattern stepping, idle outside pattern mode
        if (!pat_active) begin
            st_d.idx = '0;
        end else if (step_if.step) begin
            st_d.upd = 1'b1;
            if (st_q.idx >= st_q.regs.pat[3:0]) begin
                st_d.idx = '0;
            end else begin
                st_d.idx = st_q.idx + 4'h1;
            end
        end
        unique case (st_q.eng)
            ST_RUN: begin
                if (wr_in) begin
                    unique case (addr_in)
                        OFS_DRV_CTRL: st_d.regs.drv = wdata_in & MASK_DRV;
                        OFS_CNV_CTRL: st_d.regs.cnv = wdata_in & MASK_CNV;
                        OFS_PAT_CTRL: st_d.regs.pat = wdata_in & MASK_PAT;
                        OFS_REINIT: begin
                            if (wdata_in[BIT_REINIT]) begin
                                // whole register set back to defaults at once
                                st_d.regs = '{drv: RST_DRV, cnv: RST_CNV, pat: RST_PAT};
                                st_d.sd_latch = 1'b0;
                                st_d.idx = '0;
                                st_d.eng = ST_REBOOT;
                                st_d.boot_cnt = REBOOT_CYCLES;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_REBOOT: begin
                // writes ignored while the engine reboots
                st_d.boot_cnt = st_q.boot_cnt - 4'h1;
                if (st_q.boot_cnt == 4'h1) begin
                    st_d.eng = ST_RUN;
                end
            end
            default: st_d.eng = ST_RUN;
        endcase
        if (rd_in) begin
            unique case (addr_in)
                OFS_DRV_CTRL: st_d.rdata = st_q.regs.drv;
                OFS_CNV_CTRL: st_d.rdata = st_q.regs.cnv;
                OFS_PAT_CTRL: st_d.rdata = st_q.regs.pat;
                // reinit bit self-clears, so it reads zero
                OFS_REINIT: st_d.rdata = '0;
                OFS_STATUS: st_d.rdata = {2'h0, (st_q.eng == ST_REBOOT), st_q.sd_latch, st_q.idx};
                default: st_d.rdata = '0;
            endcase
        end
        st_d.drv_en = drv_on;
        st_d.drv_float = ~run_en;
        // converter off when asleep, or on driver shutdown unless kept on
        st_d.cnv_on = ~st_q.regs.cnv[BIT_CNV_PDOWN]
            & (drv_on | st_q.regs.cnv[BIT_KEEP_CNV_ON]);
        st_d.pat_mode = pat_active;
        st_d.twos = st_q.regs.cnv[BIT_CODE_FMT];
        // registered copy of the next engine state keeps the pin off the decode
        st_d.booting = (st_d.eng == ST_REBOOT);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '{regs: '{drv: RST_DRV, cnv: RST_CNV, pat: RST_PAT},
                      sd_latch: 1'b0, idx: 4'h0, upd: 1'b0, eng: ST_RUN,
                      boot_cnt: 4'h0, rdata: 8'h00, drv_en: 1'b1,
                      drv_float: 1'b0, cnv_on: 1'b0, pat_mode: 1'b0, twos: 1'b0,
                      booting: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_out = st_q.rdata;
    assign driver_enable_out = st_q.drv_en;
    assign driver_float_out = st_q.drv_float;
    assign converter_on_out = st_q.cnv_on;
    assign pattern_mode_out = st_q.pat_mode;
    assign twos_complement_out = st_q.twos;
    assign pattern_index_out = st_q.idx;
    assign pattern_update_out = st_q.upd;
    assign rebooting_out = st_q.booting;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_reinit_wr;
        wr_in && addr_in == OFS_REINIT && wdata_in[BIT_REINIT] && st_q.eng == ST_RUN;
    endsequence

    property p_clear_release;
        @(posedge clk_in) disable iff (!rst_n_in) clear_held |=> !st_q.sd_latch;
    endproperty
    a_clear_release: assert property (p_clear_release) else $error("latch not released");

    property p_clear_blocks;
        @(posedge clk_in) disable iff (!rst_n_in)
            clear_held && shutdown_pin_in |=> !st_q.sd_latch;
    endproperty
    a_clear_blocks: assert property (p_clear_blocks) else $error("shutdown not blocked");

    property p_run_off;
        @(posedge clk_in) disable iff (!rst_n_in)
            !run_en |=> !driver_enable_out && driver_float_out;
    endproperty
    a_run_off: assert property (p_run_off) else $error("driver not forced off");

    property p_pin_shutdown;
        @(posedge clk_in) disable iff (!rst_n_in)
            !clear_held && shutdown_pin_in && !reinit_wr ##1 !clear_held
            |=> !driver_enable_out;
    endproperty
    a_pin_shutdown: assert property (p_pin_shutdown) else $error("pin shutdown ignored");

    property p_pat_mode;
        @(posedge clk_in) disable iff (!rst_n_in) ##1 pattern_mode_out == $past(pat_active);
    endproperty
    a_pat_mode: assert property (p_pat_mode) else $error("pattern mode wrong");

    property p_cnv;
        @(posedge clk_in) disable iff (!rst_n_in)
            st_q.regs.cnv[BIT_CNV_PDOWN] |=> !converter_on_out;
    endproperty
    a_cnv: assert property (p_cnv) else $error("converter not asleep");

    property p_keep;
        @(posedge clk_in) disable iff (!rst_n_in)
            !drv_on && !st_q.regs.cnv[BIT_KEEP_CNV_ON] |=> !converter_on_out;
    endproperty
    a_keep: assert property (p_keep) else $error("converter left on");

    property p_wrap;
        @(posedge clk_in) disable iff (!rst_n_in)
            pat_active && step_if.step && st_q.idx == st_q.regs.pat[3:0] |=> st_q.idx == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("index did not wrap");

    property p_reinit;
        @(posedge clk_in) disable iff (!rst_n_in)
            s_reinit_wr |=> (st_q.regs.drv == RST_DRV && rebooting_out) [*8] ##1 !rebooting_out;
    endproperty
    a_reinit: assert property (p_reinit) else $error("reinit sequence wrong");

    property p_reserved;
        @(posedge clk_in) disable iff (!rst_n_in) (st_q.regs.drv & ~MASK_DRV) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_run_on;
        @(posedge clk_in) disable iff (!rst_n_in) run_en |=> !driver_float_out;
    endproperty
    a_run_on: assert property (p_run_on) else $error("driver floated while enabled");

    property p_source_awg;
        @(posedge clk_in) disable iff (!rst_n_in)
            !st_q.regs.drv[BIT_SRC_SELECT] |=> !pattern_mode_out;
    endproperty
    a_source_awg: assert property (p_source_awg) else $error("pattern mode in waveform mode");

    property p_format;
        @(posedge clk_in) disable iff (!rst_n_in)
            ##1 twos_complement_out == $past(st_q.regs.cnv[BIT_CODE_FMT]);
    endproperty
    a_format: assert property (p_format) else $error("code format wrong");

    // ----------------------------------------
    // pattern stepping checks
    // ----------------------------------------
    property p_update_pulse;
        @(posedge clk_in) disable iff (!rst_n_in)
            pat_active && step_if.step |=> pattern_update_out;
    endproperty
    a_update_pulse: assert property (p_update_pulse) else $error("update pulse missing");

    property p_update_idle;
        @(posedge clk_in) disable iff (!rst_n_in) !step_if.step |=> !pattern_update_out;
    endproperty
    a_update_idle: assert property (p_update_idle) else $error("spurious update pulse");

    property p_step_advance;
        @(posedge clk_in) disable iff (!rst_n_in)
            pat_active && step_if.step && !reinit_wr && st_q.idx < st_q.regs.pat[3:0]
            |=> st_q.idx == 4'($past(st_q.idx) + 4'h1);
    endproperty
    a_step_advance: assert property (p_step_advance) else $error("index did not advance");

    // ----------------------------------------
    // reboot checks
    // ----------------------------------------
    property p_reboot_locked;
        @(posedge clk_in) disable iff (!rst_n_in)
            rebooting_out && wr_in |=> st_q.regs == $past(st_q.regs);
    endproperty
    a_reboot_locked: assert property (p_reboot_locked) else $error("write taken in reboot");
endmodule
`default_nettype wire

// File: wdc_pkg.sv
// Purpose: shared constants and types for the waveform driver control registers
// Assumes: 8-bit registers at word indexes 0..4 on a plain strobe port
// Notes: bit positions and reset values match the register layout

package wdc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_DRV_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CNV_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_PAT_CTRL = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_REINIT = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    // field positions
    localparam int BIT_LATCH_CLEAR = 7;
    localparam int BIT_RUN_ENABLE = 4;
    localparam int BIT_SRC_SELECT = 0;
    localparam int BIT_KEEP_CNV_ON = 5;
    localparam int BIT_CNV_PDOWN = 3;
    localparam int BIT_CODE_FMT = 1;
    localparam int BIT_PAT_ENABLE = 5;
    localparam int BIT_EDGE_SEL = 4;
    localparam int BIT_REINIT = 0;
    // writable-bit masks, reserved bits stay zero
    localparam logic [DATA_W-1:0] MASK_DRV = 8'h91;
    localparam logic [DATA_W-1:0] MASK_CNV = 8'h2a;
    localparam logic [DATA_W-1:0] MASK_PAT = 8'h3f;
    // reset values
    localparam logic [DATA_W-1:0] RST_DRV = 8'h10;
    localparam logic [DATA_W-1:0] RST_CNV = 8'h08;
    localparam logic [DATA_W-1:0] RST_PAT = 8'h03;
    // reboot sequence length in clocks
    localparam logic [3:0] REBOOT_CYCLES = 4'h8;

    typedef struct packed {
        logic [DATA_W-1:0] drv;
        logic [DATA_W-1:0] cnv;
        logic [DATA_W-1:0] pat;
    } wdc_regs_t;
endpackage

// File: wdc_step_det.sv
// Purpose: synchronise the step strobe and pulse on the selected edge
// Assumes: strobe may be asynchronous to clk_in
// Notes: the first stage feeds only the second stage

`timescale 1ns/10ps
`default_nettype none
module wdc_step_det (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic strobe_in,
    wdc_step_if.src step_if
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic step;
    } wdc_det_t;
    wdc_det_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = strobe_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.step = step_if.edge_sel ? (st_q.s3 & ~st_q.s2) : (~st_q.s3 & st_q.s2);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign step_if.step = st_q.step;
endmodule
`default_nettype wire

// File: wdc_step_if.sv
// Purpose: carries step events and the edge select between engine modules
// Assumes: single clock domain
// Notes: none

`timescale 1ns/10ps
`default_nettype none
interface wdc_step_if;
    logic step;
    logic edge_sel;
    modport src(output step, input edge_sel);
    modport dst(input step, output edge_sel);
endinterface
`default_nettype wire

// File: wdc_tb.sv
// Purpose: self-checking bench for the waveform driver control registers
// Assumes: strobe register port, read data one cycle after the read strobe
// Notes: fixed-seed random register traffic plus hand-picked corners

`timescale 1ns/10ps
`default_nettype none
module testbench;
    import wdc_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [DATA_W-1:0] wdata_in = '0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic shutdown_pin_in = 1'b0;
    logic fault_in = 1'b0;
    logic step_strobe_in = 1'b0;
    logic [DATA_W-1:0] rdata_out;
    logic driver_enable_out, driver_float_out, converter_on_out, pattern_mode_out;
    logic twos_complement_out, pattern_update_out, rebooting_out;
    logic [3:0] pattern_index_out;
    logic [3:0] exp_idx = 4'h0;
    logic [3:0] last;
    logic [7:0] d;
    logic [3:0] a;
    int failures = 0;
    int checks = 0;
    int upd_seen = 0;
    int exp_upd = 0;

    wdc_ctrl_regs uut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .shutdown_pin_in, .fault_in, .step_strobe_in, .driver_enable_out, .driver_float_out,
        .converter_on_out, .pattern_mode_out, .twos_complement_out, .pattern_index_out,
        .pattern_update_out, .rebooting_out);

    always #4 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        if (pattern_update_out === 1'b1) begin
            upd_seen <= upd_seen + 1;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [3:0] next_idx(input logic [3:0] i, input logic [3:0] lim);
        return (i >= lim) ? 4'h0 : i + 4'h1;
    endfunction

    function automatic logic [7:0] mask_of(input logic [3:0] adr);
        case (adr)
            OFS_DRV_CTRL: return MASK_DRV;
            OFS_CNV_CTRL: return MASK_CNV;
            OFS_PAT_CTRL: return MASK_PAT;
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] adr, input logic [7:0] dat);
        @(posedge clk_in);
        addr_in <= adr;
        wdata_in <= dat;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic reg_check(input logic [3:0] adr, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= adr;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        check(rdata_out, exp);
    endtask

    // outputs trail a write by two registered stages
    task automatic settle;
        repeat (4) @(posedge clk_in);
        #1;
    endtask

    task automatic pin(input logic sd, input logic flt);
        @(posedge clk_in);
        shutdown_pin_in <= sd;
        fault_in <= flt;
        settle();
    endtask

    // long gap per toggle so the synchroniser always sees a clean level
    task automatic run_steps(input logic [3:0] lim, input logic fall);
        for (int k = 0; k < 2 * int'(lim) + 6; k++) begin
            @(posedge clk_in);
            step_strobe_in <= ~step_strobe_in;
            if (step_strobe_in == fall) begin
                exp_idx = next_idx(exp_idx, lim);
                exp_upd++;
            end
            repeat (8) @(posedge clk_in);
            #1;
            check(pattern_index_out, exp_idx);
        end
    endtask

    task automatic results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        results();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        void'($urandom(1));
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        settle();
        check(driver_enable_out, 8'h01);
        check(driver_float_out, 8'h00);
        check(converter_on_out, 8'h00);
        check(pattern_mode_out, 8'h00);
        check(twos_complement_out, 8'h00);
        reg_check(OFS_DRV_CTRL, RST_DRV);
        reg_check(OFS_CNV_CTRL, RST_CNV);
        reg_check(OFS_PAT_CTRL, RST_PAT);
        reg_check(OFS_REINIT, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            a = (i % 6 == 5) ? 4'hf : 4'($urandom_range(2));
            // mapped registers only ever see their writable bits
            d = 8'($urandom) & ((a == 4'hf) ? 8'hff : mask_of(a));
            reg_write(a, d);
            reg_check(a, d & mask_of(a));
        end
        reg_write(OFS_REINIT, 8'hfe);
        reg_check(OFS_REINIT, 8'h00);
        reg_write(OFS_DRV_CTRL, RST_DRV);
        reg_write(OFS_CNV_CTRL, 8'h00);
        settle();
        check(converter_on_out, 8'h01);
        $display("test registers done");
        pin(1'b1, 1'b0);
        check(driver_enable_out, 8'h00);
        check(converter_on_out, 8'h00);
        reg_check(OFS_STATUS, 8'h10);
        pin(1'b0, 1'b0);
        check(driver_enable_out, 8'h00);
        reg_write(OFS_DRV_CTRL, 8'h90);
        settle();
        check(driver_enable_out, 8'h01);
        pin(1'b1, 1'b0);
        check(driver_enable_out, 8'h01);
        pin(1'b0, 1'b0);
        reg_write(OFS_DRV_CTRL, 8'h10);
        reg_write(OFS_CNV_CTRL, 8'h20);
        pin(1'b0, 1'b1);
        check(driver_enable_out, 8'h00);
        check(converter_on_out, 8'h01);
        pin(1'b0, 1'b0);
        reg_write(OFS_DRV_CTRL, 8'h90);
        reg_write(OFS_DRV_CTRL, 8'h10);
        reg_write(OFS_CNV_CTRL, 8'h2a);
        settle();
        check(driver_enable_out, 8'h01);
        check(converter_on_out, 8'h00);
        check(twos_complement_out, 8'h01);
        reg_write(OFS_DRV_CTRL, 8'h80);
        settle();
        check(driver_enable_out, 8'h00);
        check(driver_float_out, 8'h01);
        $display("test shutdown done");
        for (int j = 0; j < 2; j++) begin
            last = j ? 4'hf : 4'($urandom_range(14, 1));
            reg_write(OFS_DRV_CTRL, 8'h11);
            reg_write(OFS_PAT_CTRL, {4'h0, last});
            settle();
            check(pattern_mode_out, 8'h00);
            exp_idx = 4'h0;
            reg_write(OFS_PAT_CTRL, {4'h2, last});
            settle();
            check(pattern_mode_out, 8'h01);
            run_steps(last, 1'b0);
            reg_write(OFS_PAT_CTRL, {4'h3, last});
            run_steps(last, 1'b1);
            check(8'(upd_seen), 8'(exp_upd));
            reg_write(OFS_DRV_CTRL, 8'h10);
            settle();
            check(pattern_mode_out, 8'h00);
        end
        $display("test pattern done");
        reg_write(OFS_DRV_CTRL, 8'h81);
        reg_write(OFS_PAT_CTRL, 8'h27);
        reg_write(OFS_REINIT, 8'h01);
        repeat (2) @(posedge clk_in);
        #1;
        check(rebooting_out, 8'h01);
        // a write inside the reboot window must be dropped
        reg_write(OFS_CNV_CTRL, 8'h20);
        for (int t = 0; t < 40 && rebooting_out !== 1'b0; t++) begin
            @(posedge clk_in);
            #1;
        end
        check(rebooting_out, 8'h00);
        check(driver_enable_out, 8'h01);
        reg_check(OFS_DRV_CTRL, RST_DRV);
        reg_check(OFS_PAT_CTRL, RST_PAT);
        reg_check(OFS_CNV_CTRL, RST_CNV);
        reg_check(OFS_REINIT, 8'h00);
        $display("test reinit done");
        results();
    end
endmodule
`default_nettype wire
